/* common/aclo_defs.svh */
// Purpose: named offsets, fields, reset values and levels of the optimizer
// Assumes: register index times four is the APB byte address
// Notes: included by its bare name
`ifndef ACLO_DEFS_SVH
`define ACLO_DEFS_SVH
`define ACLO_IDX_VCHEND  8'h06
`define ACLO_IDX_PROFMSB 8'h07
`define ACLO_IDX_CMD     8'h08
`define ACLO_IDX_SET1    8'h09
`define ACLO_IDX_CFGMAX  8'h12
`define ACLO_IDX_MARGIN  8'h13
`define ACLO_IDX_STAT    8'h14
`define ACLO_CMD_START   0
`define ACLO_CMD_ACT     2
`define ACLO_CMD_RSTPF   3
`define ACLO_CMD_PLO     4
`define ACLO_CFG_MAXBIT  4
`define ACLO_VFIX_LO     4
`define ACLO_RST_MARGIN  2'h3
`define ACLO_RST_PROF    6'h01
`define ACLO_RST_VFIX    4'h8
`define ACLO_RST_MAXSEL  1'h1
`define ACLO_CEIL_HI     4'hF
`define ACLO_CEIL_LO     4'hB
`define ACLO_LEVEL_MIN   4'h0
`define ACLO_WELL_BELOW  4'h2
`define ACLO_STEP_BIG    4'h2
`define ACLO_STEP_ONE    4'h1
`endif

/* common/aclo_pkg.sv */
// Purpose: types shared by the charge level optimizer
// Assumes: 12-bit APB byte address, 32-bit data
// Notes: constants live in aclo_defs.svh
package aclo_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } aclo_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } aclo_apb_rsp_t;
   typedef enum logic [1:0] {ST_IDLE, ST_CHARGE, ST_ACTIVE, ST_UPDATE}
      aclo_state_t;
endpackage

/* logic/aclo_top.sv */
// Purpose: learns a storage capacitor charge target per load profile
// Assumes: capLevel is stable when activeDonePin rises
// Notes: APB slave, one wait-free access phase per transfer
// Function
// - Each profile keeps its own learned target code in internal flops.
// - Profile zero never learns and charges to the fixed level.
// - Learning start loads the ceiling chosen by the max-level bit.
// - Register write or start pin begins an on-demand charge to target.
// - Charge done moves the device into the active cycle.
// - At active end leftover level is compared with the margin threshold.
// - Leftover above threshold lowers the target by exactly one, except at code zero where it holds.
// - Leftover below threshold raises the target by one or two, never past the ceiling.
// - Leftover equal to threshold leaves the target unchanged.
// - Power-on or a reset-bit write restarts the profile from ceiling.
// - Leftover well below threshold raises the target by two.
// - Leftover moderately below threshold raises the target by one.
// - Margin resets to binary 11, selected profile to one.
// - Max-level bit set gives a ceiling of code fifteen.
// - Lighter load keeps lowering the target cycle by cycle.
// - Heavier load keeps raising the target cycle by cycle.
// - Up to sixty-four profiles, six-bit select over two registers.
//
// The placing of the registers and the APB register port are this design's own decisions.
`include "aclo_defs.svh"
module aclo_top #(
   parameter int PROF_N = 64
) (
   input  wire logic                   clk_sys,
   input  wire logic                   arst_n,
   input  wire aclo_pkg::aclo_apb_req_t apbReq,
   output      aclo_pkg::aclo_apb_rsp_t apbRsp,
   input  wire logic                   startPin,
   input  wire logic                   chargeDonePin,
   input  wire logic                   activeDonePin,
   input  wire logic [3:0]             capLevel,
   output      logic                   chargeEn,
   output      logic                   activeEn,
   output      logic [3:0]             targetLevel,
   output      logic                   learnMode
);
   import aclo_pkg::*;

   // ****************************************
   // Level arithmetic
   // ****************************************
   function automatic logic [3:0] sat_add(input logic [3:0] cur,
                                          input logic [3:0] step,
                                          input logic [3:0] ceil);
      logic [4:0] sum;
      sum = {1'b0, cur} + {1'b0, step};
      if (sum > {1'b0, ceil}) begin
         return ceil;
      end
      return sum[3:0];
   endfunction

   function automatic logic [3:0] next_level(input logic [3:0] cur,
                                             input logic [3:0] cap,
                                             input logic [3:0] thr,
                                             input logic [3:0] ceil);
      if (cap > thr) begin
         // Never wraps below the lowest code
         if (cur == `ACLO_LEVEL_MIN) begin
            return cur;
         end
         return cur - `ACLO_STEP_ONE;
      end
      if (cap == thr) begin
         return cur;
      end
      if ((thr - cap) >= `ACLO_WELL_BELOW) begin
         return sat_add(cur, `ACLO_STEP_BIG, ceil);
      end
      return sat_add(cur, `ACLO_STEP_ONE, ceil);
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [6:0]  meta_reg;
   logic [6:0]  sync_reg;
   logic        startDly_reg;
   logic        startEdge;
   logic        chgSync;
   logic        actSync;
   logic [3:0]  capSync;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg     <= 7'h00;
         sync_reg     <= 7'h00;
         startDly_reg <= 1'b0;
      end else begin
         meta_reg     <= {startPin, chargeDonePin, activeDonePin, capLevel};
         sync_reg     <= meta_reg;
         startDly_reg <= sync_reg[6];
      end
   end

   assign startEdge = sync_reg[6] & ~startDly_reg;
   assign chgSync   = sync_reg[5];
   assign actSync   = sync_reg[4];
   assign capSync   = sync_reg[3:0];

   // ****************************************
   // APB decode and configuration
   // ****************************************
   aclo_apb_rsp_t apbRsp_reg;
   aclo_state_t   state_reg;
   logic [5:0]    profSel_reg;
   logic [5:0]    actProf_reg;
   logic [1:0]    margin_reg;
   logic [3:0]    vfix_reg;
   logic          maxSel_reg;
   logic [3:0]    lastCap_reg;
   logic [3:0]    lvl_reg [PROF_N];
   logic [PROF_N-1:0] valid_reg;
   logic [7:0]    idx;
   logic          hit;
   logic          setup;
   logic          wrEn;
   logic          startReq;
   logic          rstReq;
   logic [5:0]    rstProf;
   logic [31:0]   rdData;
   logic [3:0]    ceil;
   logic [3:0]    thr;
   logic [3:0]    curLvlAct;
   logic          startEv;
   logic          initEv;
   logic          updEv;

   assign idx   = apbReq.paddr[9:2];
   assign setup = apbReq.psel & ~apbReq.penable;
   assign hit   = (apbReq.paddr[1:0] == 2'h0) &&
                  (apbReq.paddr[11:10] == 2'h0) &&
                  (idx == `ACLO_IDX_VCHEND  || idx == `ACLO_IDX_PROFMSB ||
                   idx == `ACLO_IDX_CMD     || idx == `ACLO_IDX_SET1    ||
                   idx == `ACLO_IDX_CFGMAX  || idx == `ACLO_IDX_MARGIN  ||
                   idx == `ACLO_IDX_STAT);
   assign wrEn  = apbReq.psel & apbReq.penable & apbRsp_reg.pready &
                  apbReq.pwrite & hit;
   assign startReq = wrEn && idx == `ACLO_IDX_CMD &&
                     apbReq.pwdata[`ACLO_CMD_START];
   assign rstReq   = wrEn && idx == `ACLO_IDX_CMD &&
                     apbReq.pwdata[`ACLO_CMD_RSTPF];
   // Reset applies to the profile named in the same write
   assign rstProf  = {profSel_reg[5:4],
                      apbReq.pwdata[`ACLO_CMD_PLO +: 4]};

   always_comb begin
      rdData = 32'h0000_0000;
      unique case (idx)
         `ACLO_IDX_VCHEND:  rdData[3:0] = lastCap_reg;
         `ACLO_IDX_PROFMSB: rdData[1:0] = profSel_reg[5:4];
         `ACLO_IDX_CMD: begin
            rdData[`ACLO_CMD_PLO +: 4] = profSel_reg[3:0];
            rdData[`ACLO_CMD_ACT]      = (state_reg == ST_ACTIVE);
         end
         `ACLO_IDX_SET1:    rdData[`ACLO_VFIX_LO +: 4] = vfix_reg;
         `ACLO_IDX_CFGMAX:  rdData[`ACLO_CFG_MAXBIT] = maxSel_reg;
         `ACLO_IDX_MARGIN:  rdData[1:0] = margin_reg;
         `ACLO_IDX_STAT: begin
            rdData[3:0] = lvl_reg[profSel_reg];
            rdData[4]   = valid_reg[profSel_reg];
            rdData[9:8] = state_reg;
         end
         default:           rdData = 32'h0000_0000;
      endcase
   end

   // One-cycle access phase: ready is raised by the setup cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         apbRsp_reg <= '0;
      end else begin
         apbRsp_reg.pready  <= setup;
         apbRsp_reg.pslverr <= setup & ~hit;
         apbRsp_reg.prdata  <= (setup && !apbReq.pwrite && hit) ?
                               rdData : 32'h0000_0000;
      end
   end
   assign apbRsp = apbRsp_reg;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         profSel_reg <= `ACLO_RST_PROF;
         margin_reg  <= `ACLO_RST_MARGIN;
         vfix_reg    <= `ACLO_RST_VFIX;
         maxSel_reg  <= `ACLO_RST_MAXSEL;
      end else if (wrEn) begin
         unique case (idx)
            `ACLO_IDX_PROFMSB: profSel_reg[5:4] <= apbReq.pwdata[1:0];
            `ACLO_IDX_CMD:
               profSel_reg[3:0] <= apbReq.pwdata[`ACLO_CMD_PLO +: 4];
            `ACLO_IDX_SET1:  vfix_reg <= apbReq.pwdata[`ACLO_VFIX_LO +: 4];
            `ACLO_IDX_CFGMAX: maxSel_reg <= apbReq.pwdata[`ACLO_CFG_MAXBIT];
            `ACLO_IDX_MARGIN: margin_reg <= apbReq.pwdata[1:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Cycle sequencer
   // ****************************************
   assign ceil      = maxSel_reg ? `ACLO_CEIL_HI : `ACLO_CEIL_LO;
   assign thr       = {2'h0, margin_reg};
   assign curLvlAct = lvl_reg[actProf_reg];
   assign startEv   = (state_reg == ST_IDLE) && (startReq || startEdge);
   assign initEv    = startEv && profSel_reg != 6'h00 &&
                      !valid_reg[profSel_reg];
   assign updEv     = (state_reg == ST_UPDATE) && actProf_reg != 6'h00;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg   <= ST_IDLE;
         actProf_reg <= `ACLO_RST_PROF;
         targetLevel <= `ACLO_LEVEL_MIN;
         learnMode   <= 1'b0;
         chargeEn    <= 1'b0;
         activeEn    <= 1'b0;
         lastCap_reg <= `ACLO_LEVEL_MIN;
      end else begin
         unique case (state_reg)
            ST_IDLE: if (startEv) begin
               state_reg   <= ST_CHARGE;
               actProf_reg <= profSel_reg;
               chargeEn    <= 1'b1;
               learnMode   <= profSel_reg != 6'h00;
               if (profSel_reg == 6'h00) begin
                  targetLevel <= vfix_reg;
               end else if (!valid_reg[profSel_reg]) begin
                  targetLevel <= ceil;
               end else begin
                  targetLevel <= lvl_reg[profSel_reg];
               end
            end
            ST_CHARGE: if (chgSync) begin
               state_reg <= ST_ACTIVE;
               chargeEn  <= 1'b0;
               activeEn  <= 1'b1;
            end
            ST_ACTIVE: if (actSync) begin
               state_reg   <= ST_UPDATE;
               activeEn    <= 1'b0;
               lastCap_reg <= capSync;
            end
            ST_UPDATE: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Per-profile learned storage
   // ****************************************
   // Flops, not RAM: every entry is reset to unlearned at power-on
   for (genvar i = 0; i < PROF_N; i++) begin : g_prof
      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            valid_reg[i] <= 1'b0;
            lvl_reg[i]   <= `ACLO_CEIL_HI;
         end else begin
            if (rstReq && rstProf == 6'(i)) begin
               valid_reg[i] <= 1'b0;
            end
            // An initialising start (initEv) in the same cycle wins over the reset bit
            if (initEv && profSel_reg == 6'(i)) begin
               valid_reg[i] <= 1'b1;
               lvl_reg[i]   <= ceil;
            end
            if (updEv && actProf_reg == 6'(i)) begin
               lvl_reg[i] <= next_level(lvl_reg[i], lastCap_reg,
                                        thr, ceil);
            end
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence sStartIdle;
      state_reg == ST_IDLE && (startReq || startEdge);
   endsequence
   sequence sUpd;
      state_reg == ST_UPDATE && actProf_reg != 6'h00;
   endsequence

   chk_start_charge: assert property (sStartIdle |=> chargeEn &&
      state_reg == ST_CHARGE) else $error("start did not charge");
   chk_fixed_level: assert property (
      sStartIdle ##0 profSel_reg == 6'h00 |=>
      targetLevel == $past(vfix_reg) && !learnMode)
      else $error("profile zero not on fixed level");
   chk_init_ceiling: assert property (
      sStartIdle ##0 profSel_reg != 6'h00 ##0 !valid_reg[profSel_reg] |=>
      targetLevel == ($past(maxSel_reg) ? `ACLO_CEIL_HI : `ACLO_CEIL_LO))
      else $error("learning did not start at ceiling");
   chk_charge_active: assert property (
      state_reg == ST_CHARGE && chgSync |=> activeEn && !chargeEn ##1
      activeEn) else $error("active cycle not entered");
   chk_dec_one: assert property (
      sUpd ##0 lastCap_reg > thr ##0 curLvlAct != 4'h0 |=>
      curLvlAct == $past(curLvlAct) - 4'h1) else $error("bad decrement");
   chk_hold_equal: assert property (
      sUpd ##0 lastCap_reg == thr |=> $stable(curLvlAct))
      else $error("target moved on equal leftover");
   // Differences taken only below threshold so 4-bit differences cannot wrap
   chk_inc_two: assert property (
      sUpd ##0 lastCap_reg < thr ##0 thr - lastCap_reg >= 4'h2 ##0
      curLvlAct <= ceil - 4'h2 |=> curLvlAct == $past(curLvlAct) + 4'h2)
      else $error("bad +2");
   chk_inc_one: assert property (
      sUpd ##0 lastCap_reg < thr ##0 thr - lastCap_reg == 4'h1 ##0
      curLvlAct < ceil |=> curLvlAct == $past(curLvlAct) + 4'h1)
      else $error("bad +1");
   chk_ceil_sat: assert property (
      sUpd ##0 lastCap_reg < thr ##0 curLvlAct >= ceil - 4'h1 |=>
      curLvlAct == $past(ceil)) else $error("target passed ceiling");
   chk_floor_hold: assert property (
      sUpd ##0 curLvlAct == 4'h0 ##0 lastCap_reg > thr |=>
      curLvlAct == 4'h0) else $error("target wrapped below floor");
   chk_reset_prof: assert property (
      rstReq && !initEv |=> !valid_reg[$past(rstProf)])
      else $error("profile reset ignored");
endmodule

/* sim/aclo_load_model.sv */
// Purpose: charge path and pulsed load beside the optimizer
// Assumes: bench sets leftCode before a cycle starts
// Notes: slow stretches both the charge and the active phase
module aclo_load_model (
   input  wire logic       clk_sys,
   input  wire logic       chargeEn,
   input  wire logic       activeEn,
   input  wire logic       slow,
   input  wire logic [3:0] leftCode,
   output      logic       chargeDonePin,
   output      logic       activeDonePin,
   output      logic [3:0] capLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] waitCnt = 8'h00;
   logic       actSeen = 1'b0;
   logic [7:0] dly;
   assign dly = slow ? 8'h0C : 8'h00;
   initial begin
      chargeDonePin = 1'b0;
      activeDonePin = 1'b0;
      capLevel = 4'h0;
   end
   // Count restarts on active entry so the leftover code settles first
   always @(posedge clk_sys) begin
      actSeen <= activeEn;
      if ((chargeEn || activeEn) && !(activeEn && !actSeen))
         waitCnt <= waitCnt + 8'h01;
      else
         waitCnt <= 8'h00;
      chargeDonePin <= chargeEn && waitCnt >= dly;
      activeDonePin <= activeEn && actSeen && waitCnt >= dly + 8'h04;
      capLevel <= activeEn ? leftCode : ~leftCode;
   end
endmodule

/* sim/adaptive_charge_level_optimizer_bench.sv */
// Purpose: self-checking bench for the charge level optimizer
// Assumes: APB slave answers with no wait states, pins synced in two flops
// Notes: expected levels come from a bench copy of the update law
`include "aclo_defs.svh"
module adaptive_charge_level_optimizer_bench;
   import aclo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic          clk_sys = 1'b0;
   logic          arst_n = 1'b0;
   aclo_apb_req_t apbReq = '0;
   aclo_apb_rsp_t apbRsp;
   logic          startPin = 1'b0;
   logic          slow = 1'b0;
   logic          chargeDonePin, activeDonePin, chargeEn, activeEn;
   logic          learnMode;
   logic [3:0]    capLevel, targetLevel;
   logic [3:0]    leftCode = 4'h0;
   logic [31:0]   rnd = 32'h252B;
   logic [5:0]    prof = 6'h01;
   logic [3:0]    vfix = 4'h8;
   logic [1:0]    thr = 2'h3;
   logic          maxBit = 1'b1;
   logic [3:0]    lvl [64];
   logic          lrn [64];
   logic [3:0]    seqCap [8] = '{4'h5, 4'h5, 4'h5, 4'h3, 4'h2, 4'h0,
                                 4'h0, 4'h9};
   logic [31:0]   r;
   logic          e;
   int            fail_count = 0;
   int            num_checks = 0;
   int            cycles = 0;
   always #5 clk_sys = ~clk_sys;
   aclo_top #(.PROF_N(64)) u_aclo_top (.clk_sys(clk_sys), .arst_n(arst_n),
      .apbReq(apbReq), .apbRsp(apbRsp), .startPin(startPin),
      .chargeDonePin(chargeDonePin), .activeDonePin(activeDonePin),
      .capLevel(capLevel), .chargeEn(chargeEn), .activeEn(activeEn),
      .targetLevel(targetLevel), .learnMode(learnMode));
   aclo_load_model u_aclo_load_model (.clk_sys(clk_sys),
      .chargeEn(chargeEn), .activeEn(activeEn), .slow(slow),
      .leftCode(leftCode), .chargeDonePin(chargeDonePin),
      .activeDonePin(activeDonePin), .capLevel(capLevel));
   // ***************************************
   // Helpers
   // ***************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [3:0] nextLvl(input int l, c, t, ceil);
      if (c > t)
         l = (l == 0) ? 0 : l - 1;
      else if (c < t)
         l = l + ((t - c >= `ACLO_WELL_BELOW) ? 2 : 1);
      if (l > ceil)
         l = ceil;
      return l[3:0];
   endfunction
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Request held until the edge that samples pready high
   task automatic apb(input logic [7:0] idx, input logic wr,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      apbReq <= '{paddr: {2'b00, idx, 2'b00}, psel: 1'b1, penable: 1'b0,
                  pwrite: wr, pwdata: wd};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      // The wait has no cycle limit: only the run timeout ends a hang
      do begin
         @(posedge clk_sys);
         n++;
      end while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      chk(n, 32'h1, "access not wait-free");
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(idx, 1'b1, d, r, e);
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [31:0] x,
                        input string what);
      apb(idx, 1'b0, 32'h0, r, e);
      chk(r, x, what);
   endtask
   task automatic setProf(input logic [5:0] p);
      prof = p;
      wr(`ACLO_IDX_PROFMSB, {30'h0, p[5:4]});
      wr(`ACLO_IDX_CMD, {24'h0, p[3:0], 4'h0});
   endtask
   task automatic waitLvl(input int sel, input logic val);
      int n;
      n = 0;
      #1;
      while ((sel == 0 ? chargeEn : activeEn) !== val && n < 100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 100)
         chk(32'h0, 32'h1, "no handshake");
   endtask
   task automatic runCyc(input logic viaPin, input logic [3:0] cap);
      logic [3:0] ceil;
      logic [3:0] x;
      ceil = maxBit ? `ACLO_CEIL_HI : `ACLO_CEIL_LO;
      if (prof != 6'h00 && !lrn[prof]) begin
         lvl[prof] = ceil;
         lrn[prof] = 1'b1;
      end
      x = (prof == 6'h00) ? vfix : lvl[prof];
      rnd = lfsr(rnd);
      @(posedge clk_sys);
      leftCode <= cap;
      slow <= rnd[0];
      if (viaPin) begin
         startPin <= 1'b1;
         repeat (4) @(posedge clk_sys);
         startPin <= 1'b0;
      end else
         wr(`ACLO_IDX_CMD, {24'h0, prof[3:0], 4'h1});
      waitLvl(0, 1'b1);
      chk(targetLevel, x, "target");
      chk(learnMode, prof != 6'h00, "learn mode");
      waitLvl(1, 1'b1);
      chk(chargeEn, 1'b0, "charge off in active");
      waitLvl(1, 1'b0);
      repeat (3) @(posedge clk_sys);
      rdChk(`ACLO_IDX_VCHEND, cap, "leftover");
      if (prof != 6'h00) begin
         lvl[prof] = nextLvl(lvl[prof], cap, thr, ceil);
         rdChk(`ACLO_IDX_STAT, {27'h0, 1'b1, lvl[prof]}, "level");
      end
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         $display("BAD %0t run too long", $time);
         test_done();
      end
   end
   // ***************************************
   // Tests
   // ***************************************
   initial begin
      for (int i = 0; i < 64; i++)
         lrn[i] = 1'b0;
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      rdChk(`ACLO_IDX_MARGIN, 32'h3, "margin reset");
      rdChk(`ACLO_IDX_CMD, 32'h10, "profile reset");
      rdChk(`ACLO_IDX_CFGMAX, 32'h10, "max bit reset");
      rdChk(`ACLO_IDX_SET1, 32'h80, "fixed level reset");
      apb(`ACLO_IDX_STAT, 1'b0, 32'h0, r, e);
      chk(r[4], 1'b0, "unlearned at start");
      apb(8'h30, 1'b0, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1, "unmapped read");
      $display("test reset values done");
      foreach (seqCap[i])
         runCyc(i[0], seqCap[i]);
      $display("test corner sequence done");
      vfix = 4'h5;
      wr(`ACLO_IDX_SET1, {24'h0, vfix, 4'h0});
      setProf(6'h00);
      runCyc(1'b0, 4'h0);
      runCyc(1'b1, 4'hF);
      $display("test fixed level done");
      maxBit = 1'b0;
      wr(`ACLO_IDX_CFGMAX, 32'h0);
      setProf(6'h3F);
      repeat (13)
         runCyc(1'b0, 4'hF);
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         thr = rnd[9:8];
         wr(`ACLO_IDX_MARGIN, {30'h0, thr});
         runCyc(rnd[4], {2'b00, rnd[13:12]});
      end
      $display("test random load done");
      maxBit = 1'b1;
      wr(`ACLO_IDX_CFGMAX, 32'h10);
      thr = 2'h3;
      wr(`ACLO_IDX_MARGIN, 32'h3);
      setProf(6'h01);
      runCyc(1'b1, 4'h3);
      wr(`ACLO_IDX_CMD, 32'h18);
      lrn[1] = 1'b0;
      runCyc(1'b0, 4'h3);
      $display("test profile restart done");
      test_done();
   end
endmodule
